// *** hdl/crbc_cluster.sv ***
// How it works
// R01: every four-bit per-processor vector uses bit i for processor i only, i from 0 to 3.
// R02: a low power-on reset bit resets the whole processor, debug and trace logic included.
// R03: a low core-only reset bit resets the processor and its vector unit but not its debug logic.
// R04: a low debug reset bit resets only that processor's debug, breakpoint and watchpoint logic.
// R05: a low shared-cache reset resets the shared level-2 system and snoop control unit.
// R06: a processor's first-level skip bit at 0 runs a level-1 invalidate at reset, at 1 skips it.
// R07: the second-level skip input at 0 runs a level-2 invalidate at reset, at 1 skips it.
// R08: the endianness strap loads the exception endian bit at reset, 0 low and 1 high.
// R09: the high vector strap puts the vectors at 0x00000000 for 0 and 0xFFFF0000 for 1.
// R10: the exception state strap loads the thumb exception bit at reset, 0 low and 1 high.
// R11: straps are sampled only while the processor is in reset and must stay valid through it.
// R12: the cluster identity captured at reset reads back in bits 11 to 8 of the affinity register.
// R13: while a processor's secure write block is high, its system control register ignores writes.
// R14: one output bit per processor tells whether it runs in symmetric multiprocessing mode.
// R15: all capture and sweeping runs on the one clock, and reset release is synchronised to it.
`timescale 1ns/10ps
module crbc_cluster (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // reset requests from the system, active low
    input wire logic [crbc_pkg::NCPU-1:0] CORE_POWER_ON_RESET_N_I,
    input wire logic [crbc_pkg::NCPU-1:0] CORE_ONLY_RESET_N_I,
    input wire logic [crbc_pkg::NCPU-1:0] DEBUG_LOGIC_RESET_N_I,
    input wire logic SHARED_CACHE_RESET_N_I,
    // invalidate skips
    input wire logic [crbc_pkg::NCPU-1:0] FIRST_LEVEL_INVALIDATE_SKIP_I,
    input wire logic SECOND_LEVEL_INVALIDATE_SKIP_I,
    // boot straps
    input wire logic [crbc_pkg::NCPU-1:0] ENDIANNESS_STRAP_I,
    input wire logic [crbc_pkg::NCPU-1:0] HIGH_VECTOR_STRAP_I,
    input wire logic [crbc_pkg::NCPU-1:0] EXCEPTION_STATE_STRAP_I,
    input wire logic [crbc_pkg::CLUSTER_ID_W-1:0] CLUSTER_IDENTITY_STRAP_I,
    input wire logic [crbc_pkg::NCPU-1:0] SECURE_SYSREG_WRITE_BLOCK_I,
    // register port
    input wire logic [crbc_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // domain resets and run enables toward the cores, active high
    output logic [crbc_pkg::NCPU-1:0] CORE_RESET_O,
    output logic [crbc_pkg::NCPU-1:0] DEBUG_RESET_O,
    output logic SHARED_CACHE_RESET_O,
    output logic [crbc_pkg::NCPU-1:0] CORE_RUN_O,
    // cache invalidation sweeps
    output logic [crbc_pkg::NCPU-1:0] L1_SWEEP_O,
    output logic [crbc_pkg::NCPU-1:0][crbc_pkg::L1_IDX_W-1:0] L1_SWEEP_IDX_O,
    output logic L2_SWEEP_O,
    output logic [crbc_pkg::L2_IDX_W-1:0] L2_SWEEP_IDX_O,
    // boot configuration
    output crbc_pkg::crbc_boot_t [crbc_pkg::NCPU-1:0] BOOT_CFG_O,
    output logic [crbc_pkg::NCPU-1:0][31:0] VECTOR_BASE_O,
    output logic [crbc_pkg::NCPU-1:0] MULTIPROCESSING_MODE_FLAG_O
);
    import crbc_pkg::*;

    // domain reset requests and their synchronised forms
    logic [NCPU-1:0] core_req;
    logic [NCPU-1:0] dbg_req;
    logic l2_req;
    logic [2*NCPU:0] all_req;
    logic [2*NCPU:0] all_dom;
    logic [NCPU-1:0] core_dom;
    logic [NCPU-1:0] dbg_dom;
    logic l2_dom;

    // invalidation state
    logic [NCPU-1:0] l1_sweep;
    logic [NCPU-1:0] l1_ready;
    logic l2_sweep;
    logic l2_ready;

    // captured configuration
    crbc_boot_t [NCPU-1:0] boot_ff;
    logic [NCPU-1:0][CLUSTER_ID_W-1:0] cluster_id_ff;
    logic [NCPU-1:0] smp_ff;
    logic [NCPU-1:0][31:0] vec_base_ff;
    logic [NCPU-1:0] run_ff;

    // register port decode
    logic reg_hit;
    logic [CPU_W-1:0] reg_cpu;
    logic [ADDR_OFS_W-1:0] reg_ofs;
    logic sysctl_wr;
    logic aux_wr;
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;

    // reset domains

    // power-on reset folds into both the core and the debug domain
    always_comb begin
        for (int i = 0; i < NCPU; i++) begin
            core_req[i] = ~CORE_POWER_ON_RESET_N_I[i] | ~CORE_ONLY_RESET_N_I[i]; // [R02] [R03]
            dbg_req[i] = ~CORE_POWER_ON_RESET_N_I[i] | ~DEBUG_LOGIC_RESET_N_I[i]; // [R02] [R04]
        end
    end

    assign l2_req = ~SHARED_CACHE_RESET_N_I; // [R05]

    // bit i of each vector goes only to processor i's domain
    assign all_req = {l2_req, dbg_req, core_req}; // [R01]

    crbc_rst_sync #(
        .W(2 * NCPU + 1)
    ) u_rst_sync (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .req_i(all_req),
        .rst_o(all_dom)
    ); // [R15]

    assign core_dom = all_dom[NCPU-1:0];
    assign dbg_dom = all_dom[2*NCPU-1:NCPU];
    assign l2_dom = all_dom[2*NCPU];

    // core reset leaves the debug domain alone, and the other way round
    assign CORE_RESET_O = core_dom; // [R03]
    assign DEBUG_RESET_O = dbg_dom; // [R04]
    assign SHARED_CACHE_RESET_O = l2_dom; // [R05]

    // cache invalidation

    for (genvar g = 0; g < NCPU; g++) begin : g_l1
        crbc_cache_sweep #(
            .IDX_W(L1_IDX_W),
            .LINES(L1_SWEEP_LINES)
        ) u_l1_sweep (
            .clk_i(MCLK_I),
            .rst_i(RST_I),
            .dom_rst_i(core_dom[g]),
            .skip_i(FIRST_LEVEL_INVALIDATE_SKIP_I[g]),
            .sweep_o(l1_sweep[g]),
            .idx_o(L1_SWEEP_IDX_O[g]),
            .ready_o(l1_ready[g])
        ); // [R06]
    end

    crbc_cache_sweep #(
        .IDX_W(L2_IDX_W),
        .LINES(L2_SWEEP_LINES)
    ) u_l2_sweep (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .dom_rst_i(l2_dom),
        .skip_i(SECOND_LEVEL_INVALIDATE_SKIP_I),
        .sweep_o(l2_sweep),
        .idx_o(L2_SWEEP_IDX_O),
        .ready_o(l2_ready)
    ); // [R07]

    assign L1_SWEEP_O = l1_sweep;
    assign L2_SWEEP_O = l2_sweep;

    // a core may not fetch until both its own and the shared cache are clean
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            run_ff <= '0;
        end else begin
            for (int i = 0; i < NCPU; i++) begin
                run_ff[i] <= ~core_dom[i] & l1_ready[i] & l2_ready; // [R06] [R07]
            end
        end
    end

    assign CORE_RUN_O = run_ff;

    // register port decode

    assign reg_hit = ~REG_ADDR_I[ADDR_MAP_BIT];
    assign reg_cpu = REG_ADDR_I[ADDR_CPU_LSB +: CPU_W];
    assign reg_ofs = REG_ADDR_I[ADDR_OFS_W-1:0];

    // secure block gates only the system control word; aux stays writable
    assign sysctl_wr = REG_WR_I & reg_hit & (reg_ofs == OFS_SYSCTL)
                       & ~SECURE_SYSREG_WRITE_BLOCK_I[reg_cpu]; // [R13]
    assign aux_wr = REG_WR_I & reg_hit & (reg_ofs == OFS_AUXCTL);

    // boot straps

    // straps are followed every cycle of the core reset, so the value
    // held at release is the one kept; writes during reset are lost
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            boot_ff <= {NCPU{BOOT_RST}};
        end else begin
            for (int i = 0; i < NCPU; i++) begin
                if (core_dom[i]) begin // [R11]
                    boot_ff[i].ee <= ENDIANNESS_STRAP_I[i]; // [R08]
                    boot_ff[i].hivec <= HIGH_VECTOR_STRAP_I[i]; // [R09]
                    boot_ff[i].te <= EXCEPTION_STATE_STRAP_I[i]; // [R10]
                end else if (sysctl_wr && (reg_cpu == CPU_W'(i))) begin
                    boot_ff[i].ee <= REG_WDATA_I[SYSCTL_EE_BIT];
                    boot_ff[i].hivec <= REG_WDATA_I[SYSCTL_HIVEC_BIT];
                    boot_ff[i].te <= REG_WDATA_I[SYSCTL_TE_BIT];
                end
            end
        end
    end

    assign BOOT_CFG_O = boot_ff;

    // cluster identity is kept per processor, caught in that processor's reset
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            cluster_id_ff <= {NCPU{CLUSTER_ID_RST}};
        end else begin
            for (int i = 0; i < NCPU; i++) begin
                if (core_dom[i]) begin
                    cluster_id_ff[i] <= CLUSTER_IDENTITY_STRAP_I; // [R11] [R12]
                end
            end
        end
    end

    // vector base follows the control bit one cycle later
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            vec_base_ff <= {NCPU{VEC_LOW}};
        end else begin
            for (int i = 0; i < NCPU; i++) begin
                vec_base_ff[i] <= boot_ff[i].hivec ? VEC_HIGH : VEC_LOW; // [R09]
            end
        end
    end

    assign VECTOR_BASE_O = vec_base_ff;

    // multiprocessing mode

    // a core leaves reset in asymmetric mode and software opts in
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            smp_ff <= '0;
        end else begin
            for (int i = 0; i < NCPU; i++) begin
                if (core_dom[i]) begin
                    smp_ff[i] <= 1'b0;
                end else if (aux_wr && (reg_cpu == CPU_W'(i))) begin
                    smp_ff[i] <= REG_WDATA_I[AUX_SMP_BIT]; // [R14]
                end
            end
        end
    end

    assign MULTIPROCESSING_MODE_FLAG_O = smp_ff; // [R14]

    // register read

    always_comb begin
        nxt_rdata = RDATA_RST;
        if (REG_RD_I && reg_hit) begin
            case (reg_ofs)
                OFS_SYSCTL: begin
                    nxt_rdata[SYSCTL_EE_BIT] = boot_ff[reg_cpu].ee;
                    nxt_rdata[SYSCTL_HIVEC_BIT] = boot_ff[reg_cpu].hivec;
                    nxt_rdata[SYSCTL_TE_BIT] = boot_ff[reg_cpu].te;
                end
                OFS_AFFINITY: begin
                    nxt_rdata[AFF_CPU_LSB +: CPU_W] = reg_cpu;
                    nxt_rdata[AFF_CLUSTER_LSB +: CLUSTER_ID_W] = cluster_id_ff[reg_cpu]; // [R12]
                end
                OFS_AUXCTL: begin
                    nxt_rdata[AUX_SMP_BIT] = smp_ff[reg_cpu];
                end
                OFS_STATUS: begin
                    nxt_rdata[ST_CORE_RST_BIT] = core_dom[reg_cpu];
                    nxt_rdata[ST_DBG_RST_BIT] = dbg_dom[reg_cpu];
                    nxt_rdata[ST_L1_SWEEP_BIT] = l1_sweep[reg_cpu];
                    nxt_rdata[ST_L1_READY_BIT] = l1_ready[reg_cpu];
                    nxt_rdata[ST_L2_RST_BIT] = l2_dom;
                    nxt_rdata[ST_L2_SWEEP_BIT] = l2_sweep;
                    nxt_rdata[ST_L2_READY_BIT] = l2_ready;
                    nxt_rdata[ST_WR_BLOCK_BIT] = SECURE_SYSREG_WRITE_BLOCK_I[reg_cpu];
                    nxt_rdata[ST_RUN_BIT] = run_ff[reg_cpu];
                end
                OFS_VECBASE: begin
                    nxt_rdata = vec_base_ff[reg_cpu];
                end
                default: begin
                    nxt_rdata = RDATA_RST;
                end
            endcase
        end
    end

    // data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_ff <= RDATA_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA_O = rdata_ff;

endmodule

// *** hdl/crbc_pkg.sv ***
package crbc_pkg;

    // cluster shape
    localparam int NCPU = 4;
    localparam int CPU_W = 2;
    localparam int CLUSTER_ID_W = 4;

    // register port decode: addr[7] must be low, addr[6:5] picks the cpu, addr[4:0] the word
    localparam int ADDR_W = 8;
    localparam int ADDR_MAP_BIT = 7;
    localparam int ADDR_CPU_LSB = 5;
    localparam int ADDR_OFS_W = 5;
    localparam logic [4:0] OFS_SYSCTL = 5'h00;
    localparam logic [4:0] OFS_AFFINITY = 5'h04;
    localparam logic [4:0] OFS_AUXCTL = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam logic [4:0] OFS_VECBASE = 5'h10;

    // system control register fields
    localparam int SYSCTL_EE_BIT = 0;
    localparam int SYSCTL_HIVEC_BIT = 1;
    localparam int SYSCTL_TE_BIT = 2;

    // affinity register fields
    localparam int AFF_CPU_LSB = 0;
    localparam int AFF_CLUSTER_LSB = 8;

    // auxiliary control and status fields
    localparam int AUX_SMP_BIT = 0;
    localparam int ST_CORE_RST_BIT = 0;
    localparam int ST_DBG_RST_BIT = 1;
    localparam int ST_L1_SWEEP_BIT = 2;
    localparam int ST_L1_READY_BIT = 3;
    localparam int ST_L2_RST_BIT = 4;
    localparam int ST_L2_SWEEP_BIT = 5;
    localparam int ST_L2_READY_BIT = 6;
    localparam int ST_WR_BLOCK_BIT = 7;
    localparam int ST_RUN_BIT = 8;

    // reset values and vector bases
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [31:0] VEC_LOW = 32'h0000_0000;
    localparam logic [31:0] VEC_HIGH = 32'hFFFF_0000;
    localparam logic [3:0] CLUSTER_ID_RST = 4'h0;

    // invalidation sweep lengths, one cycle per set
    localparam int L1_IDX_W = 7;
    localparam int L1_SWEEP_LINES = 128;
    localparam int L2_IDX_W = 9;
    localparam int L2_SWEEP_LINES = 512;

    typedef struct packed {
        logic te;
        logic hivec;
        logic ee;
    } crbc_boot_t;

    localparam crbc_boot_t BOOT_RST = 3'h0;

    typedef enum logic [1:0] {
        CRBC_SW_RESET = 2'b00,
        CRBC_SW_SWEEP = 2'b01,
        CRBC_SW_READY = 2'b11
    } crbc_sweep_t;

endpackage

// *** hdl/crbc_rst_sync.sv ***
`timescale 1ns/10ps
module crbc_rst_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // active high reset requests, level
    input wire logic [W-1:0] req_i,
    // synchronised domain resets
    output logic [W-1:0] rst_o
);
    import crbc_pkg::*;

    // assert at once, release two edges after the request drops
    for (genvar g = 0; g < W; g++) begin : g_sync
        logic arst;
        logic meta_ff;
        logic hold_ff;
        assign arst = rst_i | req_i[g];
        always_ff @(posedge clk_i or posedge arst) begin
            if (arst) begin
                meta_ff <= 1'b1;
                hold_ff <= 1'b1;
            end else begin
                meta_ff <= 1'b0;
                hold_ff <= meta_ff;
            end
        end
        assign rst_o[g] = hold_ff;
    end

endmodule

// *** hdl/crbc_cache_sweep.sv ***
`timescale 1ns/10ps
module crbc_cache_sweep #(
    parameter int IDX_W = 7,
    parameter int LINES = 128
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // domain reset and the skip strap
    input wire logic dom_rst_i,
    input wire logic skip_i,
    // sweep progress
    output logic sweep_o,
    output logic [IDX_W-1:0] idx_o,
    output logic ready_o
);
    import crbc_pkg::*;

    localparam logic [IDX_W-1:0] LAST = IDX_W'(LINES - 1);

    crbc_sweep_t state_ff;
    crbc_sweep_t nxt_state;
    logic [IDX_W-1:0] idx_ff;
    logic [IDX_W-1:0] nxt_idx;
    logic skip_ff;

    // skip is only looked at while the domain is in reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            skip_ff <= 1'b0;
        end else if (dom_rst_i) begin
            skip_ff <= skip_i;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        case (state_ff)
            CRBC_SW_RESET: begin
                nxt_idx = '0;
                if (!dom_rst_i) begin
                    nxt_state = skip_ff ? CRBC_SW_READY : CRBC_SW_SWEEP;
                end
            end
            CRBC_SW_SWEEP: begin
                if (idx_ff == LAST) begin
                    nxt_state = CRBC_SW_READY;
                end else begin
                    nxt_idx = idx_ff + 1'b1;
                end
            end
            CRBC_SW_READY: begin
                nxt_idx = '0;
            end
            default: begin
                nxt_state = CRBC_SW_RESET;
                nxt_idx = '0;
            end
        endcase
        if (dom_rst_i) begin
            nxt_state = CRBC_SW_RESET;
            nxt_idx = '0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= CRBC_SW_RESET;
            idx_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
        end
    end

    assign sweep_o = (state_ff == CRBC_SW_SWEEP);
    assign ready_o = (state_ff == CRBC_SW_READY);
    assign idx_o = idx_ff;

endmodule

// *** tb/crbc_cluster_properties.sv ***
`timescale 1ns/10ps
module crbc_cluster_properties
    import crbc_pkg::*;
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // reset requests and skip straps
    input wire logic [NCPU-1:0] CORE_POWER_ON_RESET_N_I,
    input wire logic [NCPU-1:0] CORE_ONLY_RESET_N_I,
    input wire logic [NCPU-1:0] DEBUG_LOGIC_RESET_N_I,
    input wire logic SHARED_CACHE_RESET_N_I,
    input wire logic [NCPU-1:0] FIRST_LEVEL_INVALIDATE_SKIP_I,
    // domain resets, run flags and sweeps
    input wire logic [NCPU-1:0] CORE_RESET_O,
    input wire logic [NCPU-1:0] DEBUG_RESET_O,
    input wire logic SHARED_CACHE_RESET_O,
    input wire logic [NCPU-1:0] CORE_RUN_O,
    input wire logic [NCPU-1:0] L1_SWEEP_O,
    input wire logic [NCPU-1:0][L1_IDX_W-1:0] L1_SWEEP_IDX_O,
    input wire logic L2_SWEEP_O,
    input wire logic [L2_IDX_W-1:0] L2_SWEEP_IDX_O
);
    logic [9:0] l2_cnt_ff;

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    // a sweep too long for a plain delay is counted here instead
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            l2_cnt_ff <= 10'h000;
        end else begin
            l2_cnt_ff <= L2_SWEEP_O ? l2_cnt_ff + 10'h001 : 10'h000;
        end
    end

    property p_core_req;
        ((~CORE_POWER_ON_RESET_N_I | ~CORE_ONLY_RESET_N_I) & ~CORE_RESET_O) == 4'h0;
    endproperty
    a_core_req: assert property (p_core_req) else $error("core reset missing");

    property p_dbg_req;
        ((~CORE_POWER_ON_RESET_N_I | ~DEBUG_LOGIC_RESET_N_I) & ~DEBUG_RESET_O) == 4'h0;
    endproperty
    a_dbg_req: assert property (p_dbg_req) else $error("debug reset missing");

    property p_dbg_free;
        (CORE_POWER_ON_RESET_N_I[1] && DEBUG_LOGIC_RESET_N_I[1]) [*3] |-> !DEBUG_RESET_O[1];
    endproperty
    a_dbg_free: assert property (p_dbg_free) else $error("debug reset not released");

    property p_l2_req;
        !SHARED_CACHE_RESET_N_I |-> SHARED_CACHE_RESET_O;
    endproperty
    a_l2_req: assert property (p_l2_req) else $error("shared cache reset missing");

    property p_l1_sweep;
        $fell(CORE_RESET_O[0]) && !$past(FIRST_LEVEL_INVALIDATE_SKIP_I[0]) |=>
            L1_SWEEP_O[0] && L1_SWEEP_IDX_O[0] == 7'h00 ##127
            L1_SWEEP_O[0] && L1_SWEEP_IDX_O[0] == 7'h7F ##1 !L1_SWEEP_O[0];
    endproperty
    a_l1_sweep: assert property (p_l1_sweep) else $error("l1 sweep wrong");

    property p_l1_skip;
        $fell(CORE_RESET_O[1]) && $past(FIRST_LEVEL_INVALIDATE_SKIP_I[1]) |=> !L1_SWEEP_O[1] [*4];
    endproperty
    a_l1_skip: assert property (p_l1_skip) else $error("l1 sweep not skipped");

    property p_l2_len;
        $fell(L2_SWEEP_O) |-> l2_cnt_ff == 10'h200 && $past(L2_SWEEP_IDX_O) == 9'h1FF;
    endproperty
    a_l2_len: assert property (p_l2_len) else $error("l2 sweep length wrong");

    property p_run;
        $rose(CORE_RUN_O[0]) |->
            $past(!CORE_RESET_O[0] && !L1_SWEEP_O[0] && !L2_SWEEP_O && !SHARED_CACHE_RESET_O);
    endproperty
    a_run: assert property (p_run) else $error("run before ready");
endmodule

// *** tb/crbc_sys_model.sv ***
`timescale 1ns/10ps
module crbc_sys_model (
    // clock and the core resets seen back
    input wire logic clk_i,
    input wire logic [3:0] core_rst_i,
    // reset requests, active low
    output logic [3:0] po_n_o,
    output logic [3:0] core_n_o,
    output logic [3:0] dbg_n_o,
    output logic l2_n_o,
    // straps
    output logic [3:0] l1_skip_o,
    output logic l2_skip_o,
    output logic [3:0] end_o,
    output logic [3:0] hv_o,
    output logic [3:0] te_o,
    output logic [3:0] cid_o,
    output logic [3:0] blk_o
);
    // the cluster comes up with every domain held in reset
    initial begin
        {po_n_o, core_n_o, dbg_n_o, l2_n_o, l2_skip_o} = '0;
        {l1_skip_o, end_o, hv_o, te_o, cid_o, blk_o} = '0;
    end

    // kind 0 full, 1 core only, 2 debug, 3 shared cache, 4 everything
    task automatic req(input int kind, input logic [3:0] m, e, h, t, s, c);
        @(posedge clk_i);
        end_o <= e;
        hv_o <= h;
        te_o <= t;
        l1_skip_o <= s;
        l2_skip_o <= s[0];
        cid_o <= c;
        po_n_o <= (kind == 0 || kind == 4) ? ~m : 4'hF;
        core_n_o <= (kind == 1) ? ~m : 4'hF;
        dbg_n_o <= (kind == 2) ? ~m : 4'hF;
        l2_n_o <= !(kind >= 3);
    endtask

    task automatic rel();
        int n;
        @(posedge clk_i);
        {po_n_o, core_n_o, dbg_n_o, l2_n_o} <= '1;
        for (n = 0; n < 20 && core_rst_i != 4'h0; n++) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        // hold is over: straps flip so a late capture shows
        end_o <= ~end_o;
        hv_o <= ~hv_o;
        te_o <= ~te_o;
        l1_skip_o <= ~l1_skip_o;
        cid_o <= ~cid_o;
    endtask

    task automatic set_blk(input logic [3:0] v);
        @(posedge clk_i);
        blk_o <= v;
    endtask
endmodule

// *** tb/crbc_cluster_bench.sv ***
`timescale 1ns/10ps
module crbc_cluster_bench;
    import crbc_pkg::*;
    logic MCLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic wr_s = 1'b0, rd_s = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] po_n, core_n, dbg_n, l1s, str_e, hv, te, cid, blk;
    logic [3:0] core_rst, dbg_rst, run, l1_sw, smp;
    logic l2_n, l2s, l2_rst, l2_sw;
    crbc_boot_t [NCPU-1:0] boot;
    logic [NCPU-1:0][31:0] vbase;
    logic [2:0] exp_cfg [NCPU];
    logic [3:0] exp_cid [NCPU];
    int error_cnt = 0, n_compared = 0, cyc = 0;

    always #5 MCLK_I = ~MCLK_I;

    crbc_cluster i_crbc_cluster (
        .MCLK_I(MCLK_I), .RST_I(RST_I), .CORE_POWER_ON_RESET_N_I(po_n),
        .CORE_ONLY_RESET_N_I(core_n), .DEBUG_LOGIC_RESET_N_I(dbg_n), .SHARED_CACHE_RESET_N_I(l2_n),
        .FIRST_LEVEL_INVALIDATE_SKIP_I(l1s), .SECOND_LEVEL_INVALIDATE_SKIP_I(l2s),
        .ENDIANNESS_STRAP_I(str_e), .HIGH_VECTOR_STRAP_I(hv), .EXCEPTION_STATE_STRAP_I(te),
        .CLUSTER_IDENTITY_STRAP_I(cid), .SECURE_SYSREG_WRITE_BLOCK_I(blk), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata),
        .CORE_RESET_O(core_rst), .DEBUG_RESET_O(dbg_rst), .SHARED_CACHE_RESET_O(l2_rst),
        .CORE_RUN_O(run), .L1_SWEEP_O(l1_sw), .L1_SWEEP_IDX_O(), .L2_SWEEP_O(l2_sw),
        .L2_SWEEP_IDX_O(), .BOOT_CFG_O(boot), .VECTOR_BASE_O(vbase),
        .MULTIPROCESSING_MODE_FLAG_O(smp)
    );

    crbc_sys_model i_crbc_sys_model (
        .clk_i(MCLK_I), .core_rst_i(core_rst), .po_n_o(po_n), .core_n_o(core_n),
        .dbg_n_o(dbg_n), .l2_n_o(l2_n), .l1_skip_o(l1s), .l2_skip_o(l2s), .end_o(str_e),
        .hv_o(hv), .te_o(te), .cid_o(cid), .blk_o(blk)
    );

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge MCLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] ad(input int c, input logic [4:0] o);
        return {1'b0, 2'(c), o};
    endfunction

    function automatic logic [2:0] cfg(input logic [3:0] t, h, e, input int i);
        return {t[i], h[i], e[i]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK_I);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge MCLK_I);
        wr_s <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge MCLK_I);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge MCLK_I);
        rd_s <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    task automatic chk_cfg();
        #1;
        for (int i = 0; i < NCPU; i++) begin
            chk("boot", exp_cfg[i], boot[i]);
            chk("vector", exp_cfg[i][1] ? VEC_HIGH : VEC_LOW, vbase[i]);
            rchk("sysctl", ad(i, OFS_SYSCTL), exp_cfg[i]);
            rchk("affinity", ad(i, OFS_AFFINITY), {20'h0, exp_cid[i], 6'h0, 2'(i)});
        end
    endtask

    task automatic wait_run();
        int n;
        for (n = 0; n < 700 && run !== 4'hF; n++) @(posedge MCLK_I);
        #1;
        chk("run", 32'hF, run);
    endtask

    task automatic t_boot();
        i_crbc_sys_model.req(4, 4'hF, 4'h5, 4'h3, 4'h9, 4'hA, 4'hC);
        i_crbc_sys_model.rel();
        #1;
        chk("l1 sweep", 32'h5, l1_sw);
        chk("l2 sweep", 32'h1, l2_sw);
        chk("run", 32'h0, run);
        wait_run();
        for (int i = 0; i < NCPU; i++) begin
            exp_cfg[i] = cfg(4'h9, 4'h3, 4'h5, i);
            exp_cid[i] = 4'hC;
        end
        chk_cfg();
    endtask

    task automatic t_resets();
        int cpu [3] = '{3, 1, 2};
        logic [3:0] m;
        for (int k = 0; k < 3; k++) begin
            m = 4'h1 << cpu[k];
            i_crbc_sys_model.req(k, m, 4'hA, 4'hC, 4'h6, 4'hF, 4'h5);
            repeat (4) @(posedge MCLK_I);
            #1;
            chk("core reset", k != 2 ? m : 4'h0, core_rst);
            chk("debug reset", k != 1 ? m : 4'h0, dbg_rst);
            chk("run", k != 2 ? m ^ 4'hF : 4'hF, run);
            i_crbc_sys_model.rel();
            if (k != 2) begin
                exp_cfg[cpu[k]] = cfg(4'h6, 4'hC, 4'hA, cpu[k]);
                exp_cid[cpu[k]] = 4'h5;
            end
        end
        wait_run();
        chk_cfg();
    endtask

    task automatic t_l2();
        i_crbc_sys_model.req(3, 4'h0, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF);
        repeat (4) @(posedge MCLK_I);
        #1;
        chk("l2 reset", 32'h1, l2_rst);
        chk("core reset", 32'h0, core_rst);
        chk("run", 32'h0, run);
        i_crbc_sys_model.rel();
        #1;
        chk("l2 sweep", 32'h0, l2_sw);
        wait_run();
        chk_cfg();
    endtask

    task automatic t_regs();
        wr(ad(0, OFS_SYSCTL), 32'h7);
        rchk("sysctl", ad(0, OFS_SYSCTL), 32'h7);
        i_crbc_sys_model.set_blk(4'h1);
        wr(ad(0, OFS_SYSCTL), 32'h0);
        wr(ad(3, OFS_SYSCTL), 32'h2);
        rchk("sysctl", ad(0, OFS_SYSCTL), 32'h7);
        rchk("sysctl", ad(3, OFS_SYSCTL), 32'h2);
        rchk("status", ad(0, OFS_STATUS), 32'h1C8);
        rchk("vecbase", ad(3, OFS_VECBASE), VEC_HIGH);
        i_crbc_sys_model.set_blk(4'h0);
        rchk("unmapped", 8'h84, 32'h0);
        wr(ad(1, OFS_AUXCTL), 32'h1);
        repeat (2) @(posedge MCLK_I);
        #1;
        chk("smp", 32'h2, smp);
        i_crbc_sys_model.req(1, 4'h2, 4'h0, 4'h0, 4'h0, 4'hF, 4'h0);
        repeat (4) @(posedge MCLK_I);
        #1;
        chk("smp", 32'h0, smp);
        i_crbc_sys_model.rel();
    endtask

    task automatic t_rst();
        @(posedge MCLK_I);
        RST_I <= 1'b1;
        repeat (2) @(posedge MCLK_I);
        #1;
        chk("core reset", 32'hF, core_rst);
        chk("l2 reset", 32'h1, l2_rst);
        @(posedge MCLK_I);
        RST_I <= 1'b0;
        wait_run();
    endtask

    initial begin
        repeat (4) @(posedge MCLK_I);
        RST_I <= 1'b0;
        t_boot();
        t_resets();
        t_l2();
        t_regs();
        t_rst();
        summarize();
    end
endmodule

bind crbc_cluster crbc_cluster_properties i_crbc_cluster_properties (
    .MCLK_I, .RST_I, .CORE_POWER_ON_RESET_N_I, .CORE_ONLY_RESET_N_I, .DEBUG_LOGIC_RESET_N_I,
    .SHARED_CACHE_RESET_N_I, .FIRST_LEVEL_INVALIDATE_SKIP_I, .CORE_RESET_O, .DEBUG_RESET_O,
    .SHARED_CACHE_RESET_O, .CORE_RUN_O, .L1_SWEEP_O, .L1_SWEEP_IDX_O, .L2_SWEEP_O, .L2_SWEEP_IDX_O
);
